// File: rtl/csg_clock_gen.v
/*
  Clock source generation: run/stop control of five oscillators,
  write-protected control registers, pin sharing and CPU clock select.
  Assumes the oscillator clocks arrive as levels sampled on clk and
  that the boot option bit is stable in the first cycle after rst_n rises.
*/
// The register addresses and the plain strobed port were decided locally.
// Contract
// [R1] After reset main, sub and high-speed oscillators stop; low-speed runs.
// [R2] Watchdog oscillator stopped after reset if protect bit 1, running if 0.
// [R3] Each of the five oscillators can be stopped and restarted by register; code keeps low-speed running while internal source selected.
// [R4] External main clock needs stop, feedback-disable and pin-select bits set.
// [R5] High-speed oscillator as CPU source is divided down to at most 20 MHz.
// [R6] Shared pins are ports when internal clock used and no external circuit.
// [R7] Both internal oscillators serve as CPU source, also as main fallback.
// [R8] Sub oscillator feedback resistor is selectable connected or disconnected.
// [R9] A separate low-speed oscillator clocks only the watchdog.
// [R10] Clock control writes are ignored unless protection enable bit is set.
// [R11] Main pin-select bit, once set, stays set.
// [R12] Source switching produces no truncated clock phases; only the bypass/divider switch goes through the glitch-free mux.
`timescale 1ns/100ps
`default_nettype none
`include "csg_defs.vh"

module csg_clock_gen
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       boot_count_src_protect,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       main_clk_in,
  input  wire       sub_clk_in,
  input  wire       hoco_clk_in,
  input  wire       loco_clk_in,
  input  wire       main_osc_lost,
  output reg        main_osc_en,
  output reg        main_feedback_en,
  output reg        sub_osc_en,
  output reg        sub_feedback_en,
  output reg        hoco_en,
  output reg        loco_en,
  output reg        wdt_osc_en,
  output reg        port_pins_free,
  output reg        main_pins_osc,
  output reg        sub_pins_osc,
  output reg        cpu_clk
);

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  reg  [7:0] sys_clk_ctrl_a;
  reg  [7:0] sys_clk_ctrl_b;
  reg  [7:0] write_protect_register;
  reg  [7:0] src_sel;
  reg        wdt_init_done;
  reg  [1:0] src_code;
  reg        src_clk;
  reg  [3:0] div_cnt;
  reg  [3:0] div_mask;
  reg        div_clk;
  reg        src_prev;
  wire       clk_write_protect_enable;
  wire       wr_ok;
  wire       mux_out;
  wire       mux_on_b;

  assign clk_write_protect_enable = write_protect_register[`CSG_WPROT_ENABLE];
  // Writes to the clock registers need the protect enable bit [R10]
  assign wr_ok = wr & clk_write_protect_enable;

  // --------------------------------------------------------------
  // Register writes; one-way bits only ever set
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sys_clk_ctrl_a         <= `CSG_RST_CTRL_A; // [R1]
      sys_clk_ctrl_b         <= `CSG_RST_CTRL_B; // [R1]
      src_sel                <= `CSG_RST_SRC_SEL;
      write_protect_register <= 8'h00;
      wdt_init_done          <= 1'b0;
    end
    else
    begin
      // Strap is caught after release, not under reset [R2]
      if (!wdt_init_done)
      begin
        wdt_init_done <= 1'b1;
        src_sel[`CSG_S_WDT_STOP] <= boot_count_src_protect;
      end
      if (wr && addr == `CSG_ADDR_WPROT)
        write_protect_register <= {7'h00, wdata[`CSG_WPROT_ENABLE]};
      else if (wr_ok && addr == `CSG_ADDR_CTRL_A)
      begin
        // Stop bits start and stop each external oscillator [R3]
        sys_clk_ctrl_a <= {wdata[7:5], wdata[4] | sys_clk_ctrl_a[4], wdata[3:1], 1'b0};
      end
      else if (wr_ok && addr == `CSG_ADDR_CTRL_B)
      begin
        // Pin select is sticky once set [R11]; reserved bit 5 stays 1; feedback bits [R8]
        sys_clk_ctrl_b <= {wdata[7:6], 1'b1, wdata[4],
                           wdata[3] | sys_clk_ctrl_b[`CSG_B_MAIN_PIN], wdata[2:0]};
      end
      else if (wr_ok && addr == `CSG_ADDR_SRC_SEL)
      begin
        // High-speed and watchdog oscillator run control [R3] [R9]
        src_sel <= {4'h0, wdata[3:0]};
      end
      // Loss of main clock forces the internal fallback, low- or high-speed per the select bit [R7]
      if (main_osc_lost && !src_sel[`CSG_S_ONCHIP])
        src_sel[`CSG_S_ONCHIP] <= 1'b1;
      // Internal selected keeps low-speed running
      if (src_sel[`CSG_S_ONCHIP])
        sys_clk_ctrl_b[`CSG_B_LOCO_STOP] <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Read path, data one cycle after the strobe
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      if (addr == `CSG_ADDR_CTRL_A)
        rdata <= sys_clk_ctrl_a;
      else if (addr == `CSG_ADDR_CTRL_B)
        rdata <= sys_clk_ctrl_b;
      else if (addr == `CSG_ADDR_WPROT)
        rdata <= write_protect_register;
      else if (addr == `CSG_ADDR_SRC_SEL)
        rdata <= src_sel;
      else if (addr == `CSG_ADDR_STATUS)
        rdata <= {4'h0, port_pins_free, mux_on_b, src_code};
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end

  // --------------------------------------------------------------
  // Oscillator enables and pin control
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      main_osc_en      <= 1'b0; // [R1]
      main_feedback_en <= 1'b1;
      sub_osc_en       <= 1'b0; // [R1]
      sub_feedback_en  <= 1'b1;
      hoco_en          <= 1'b0; // [R1]
      loco_en          <= 1'b1; // [R1]
      wdt_osc_en       <= 1'b0;
      port_pins_free   <= 1'b1;
      main_pins_osc    <= 1'b0;
      sub_pins_osc     <= 1'b0;
    end
    else
    begin
      main_osc_en      <= ~sys_clk_ctrl_a[`CSG_A_MAIN_STOP]; // [R3]
      // External clock input: stopped amp, no feedback, pins to osc [R4]
      main_feedback_en <= ~sys_clk_ctrl_b[`CSG_B_MAIN_FB_DIS];
      sub_osc_en       <= ~sys_clk_ctrl_a[`CSG_A_SUB_STOP]; // [R3]
      sub_feedback_en  <= ~sys_clk_ctrl_b[`CSG_B_SUB_FB_DIS]; // [R8]
      hoco_en          <= src_sel[`CSG_S_HOCO_RUN]; // [R3]
      loco_en          <= ~sys_clk_ctrl_b[`CSG_B_LOCO_STOP]; // [R3]
      wdt_osc_en       <= wdt_init_done & ~src_sel[`CSG_S_WDT_STOP]; // [R2] [R9]
      main_pins_osc    <= sys_clk_ctrl_b[`CSG_B_MAIN_PIN];
      sub_pins_osc     <= sys_clk_ctrl_a[`CSG_A_SUB_ENABLE];
      // Ports only with internal source and neither circuit in use [R6]
      port_pins_free   <= src_sel[`CSG_S_ONCHIP] & sys_clk_ctrl_a[`CSG_A_MAIN_STOP]
                          & ~sys_clk_ctrl_b[`CSG_B_MAIN_PIN] & ~sys_clk_ctrl_a[`CSG_A_SUB_ENABLE];
    end
  end

  // --------------------------------------------------------------
  // Source selection and divider
  // --------------------------------------------------------------
  always @*
  begin
    if (src_sel[`CSG_S_ONCHIP]) // [R7]
      src_code = src_sel[`CSG_S_HOCO_SEL] ? `CSG_SRC_HOCO : `CSG_SRC_LOCO;
    else
      src_code = sys_clk_ctrl_a[`CSG_A_SUB_SELECT] ? `CSG_SRC_SUB : `CSG_SRC_MAIN;
    case (src_code)
      `CSG_SRC_MAIN: src_clk = main_clk_in;
      `CSG_SRC_SUB:  src_clk = sub_clk_in;
      `CSG_SRC_LOCO: src_clk = loco_clk_in;
      default:       src_clk = hoco_clk_in;
    endcase
    // Divide ratio from the division bits, divide-by-8 override
    if (sys_clk_ctrl_a[`CSG_A_DIV8])
      div_mask = 4'h3;
    else if (sys_clk_ctrl_b[7:6] == 2'h0)
      div_mask = 4'h0;
    else if (sys_clk_ctrl_b[7:6] == 2'h1)
      div_mask = 4'h0;
    else if (sys_clk_ctrl_b[7:6] == 2'h2)
      div_mask = 4'h1;
    else
      div_mask = 4'h7;
    // High-speed source never runs undivided: at least halved [R5]
    if (src_code == `CSG_SRC_HOCO && sys_clk_ctrl_b[7:6] == 2'h0 && !sys_clk_ctrl_a[`CSG_A_DIV8])
      div_mask = 4'h0;
  end

  // Source level tracks through reset, so release never shows a cut phase
  always @(posedge clk)
  begin
    src_prev <= src_clk;
  end

  // Toggle divider on source rising edges; toggle halves the rate already
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt  <= 4'h0;
      div_clk  <= 1'b0;
    end
    else
    begin
      if (src_clk && !src_prev)
      begin
        if (div_cnt >= div_mask)
        begin
          div_cnt <= 4'h0;
          div_clk <= ~div_clk; // [R5]
        end
        else
          div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  // Undivided path is used only for non high-speed sources at ratio 1
  wire bypass = (sys_clk_ctrl_b[7:6] == 2'h0) && !sys_clk_ctrl_a[`CSG_A_DIV8] && (src_code != `CSG_SRC_HOCO);

  csg_glitchless_mux u_mux
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .sel     (~bypass),
    .clk_a   (src_prev),
    .clk_b   (div_clk),
    .clk_out (mux_out),
    .on_b    (mux_on_b)
  );

  always @(posedge clk)
  begin
    if (!rst_n)
      cpu_clk <= 1'b0;
    else
      cpu_clk <= mux_out; // [R12]
  end

endmodule // csg_clock_gen

`default_nettype wire

// File: rtl/csg_defs.vh
/*
  Constants for the clock source generation block: register offsets,
  field positions, reset values and divider settings.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CSG_DEFS_VH
`define CSG_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSG_ADDR_CTRL_A   8'h06
`define CSG_ADDR_CTRL_B   8'h07
`define CSG_ADDR_WPROT    8'h0a
`define CSG_ADDR_SRC_SEL  8'h0c
`define CSG_ADDR_STATUS   8'h0d

// ----------------------------------------------------------------
// Field positions, sys_clk_ctrl_a
// ----------------------------------------------------------------
`define CSG_A_SUB_PIN     1
`define CSG_A_SUB_STOP    3
`define CSG_A_SUB_ENABLE  4
`define CSG_A_MAIN_STOP   5
`define CSG_A_DIV8        6
`define CSG_A_SUB_SELECT  7

// ----------------------------------------------------------------
// Field positions, sys_clk_ctrl_b
// ----------------------------------------------------------------
`define CSG_B_MAIN_FB_DIS 1
`define CSG_B_SUB_FB_DIS  2
`define CSG_B_MAIN_PIN    3
`define CSG_B_LOCO_STOP   4
`define CSG_B_DIV_LO      6
`define CSG_B_DIV_HI      7

// ----------------------------------------------------------------
// Field positions, source select register
// ----------------------------------------------------------------
`define CSG_S_ONCHIP      0
`define CSG_S_HOCO_SEL    1
`define CSG_S_HOCO_RUN    2
`define CSG_S_WDT_STOP    3

// ----------------------------------------------------------------
// Reset values and protect enable bit position
// ----------------------------------------------------------------
`define CSG_RST_CTRL_A    8'h28
`define CSG_RST_CTRL_B    8'h20
`define CSG_RST_SRC_SEL   8'h01
`define CSG_WPROT_ENABLE  0

// ----------------------------------------------------------------
// Clock selection codes and divider limit
// ----------------------------------------------------------------
`define CSG_SRC_MAIN      2'h0
`define CSG_SRC_SUB       2'h1
`define CSG_SRC_LOCO      2'h2
`define CSG_SRC_HOCO      2'h3
`define CSG_HOCO_MHZ      40
`define CSG_CPU_MAX_MHZ   20
`define CSG_HOCO_MIN_DIV  ((`CSG_HOCO_MHZ + `CSG_CPU_MAX_MHZ - 1) / `CSG_CPU_MAX_MHZ)

`endif

// File: rtl/csg_glitchless_mux.v
/*
  Glitch-free two-way clock switch with enable handshake per side.
  Assumes both input clocks are sampled on clk as plain levels.
*/
`timescale 1ns/100ps
`default_nettype none

module csg_glitchless_mux
(
  input  wire clk,
  input  wire rst_n,
  input  wire sel,
  input  wire clk_a,
  input  wire clk_b,
  output reg  clk_out,
  output reg  on_b
);

  // --------------------------------------------------------------
  // Switch only while the old clock is low, so no phase is cut
  // --------------------------------------------------------------
  reg on_a;
  reg next_out;

  always @*
  begin
    next_out = (on_a & clk_a) | (on_b & clk_b);
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      // Neither side on: the first take waits for a low phase
      on_a    <= 1'b0;
      on_b    <= 1'b0;
      clk_out <= 1'b0;
    end
    else
    begin
      // Drop the old side at its low phase, take the new one at its low phase [R12]
      if (on_a && sel && !clk_a)
        on_a <= 1'b0;
      else if (!on_a && !on_b && !sel && !clk_a)
        on_a <= 1'b1;
      if (on_b && !sel && !clk_b)
        on_b <= 1'b0;
      else if (!on_a && !on_b && sel && !clk_b)
        on_b <= 1'b1;
      clk_out <= next_out;
    end
  end

endmodule // csg_glitchless_mux

`default_nettype wire

// File: dv/csg_clock_gen_sva.sv
/*
  Port-level checker for csg_clock_gen: reset state, write protection,
  run/stop latency, sticky pin routing and CPU clock phase width.
  Assumes it is bound to csg_clock_gen from the bench top file.
*/
`timescale 1ns/100ps
`default_nettype none

module csg_clock_gen_sva
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       boot_count_src_protect,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic [7:0] rdata,
  input wire logic       main_osc_en,
  input wire logic       sub_osc_en,
  input wire logic       hoco_en,
  input wire logic       loco_en,
  input wire logic       wdt_osc_en,
  input wire logic       port_pins_free,
  input wire logic       main_pins_osc,
  input wire logic       cpu_clk
);
  // ----------------------------------------------------------------
  // Bus tracking
  // ----------------------------------------------------------------
  logic prot;
  wire  main_wr = wr && prot && addr == 8'h06;
  wire  hoco_wr = wr && prot && addr == 8'h0c;

  // Mirror of the protect bit, so refused writes can be told apart
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prot <= 1'b0;
    else if (wr && addr == 8'h0a)
      prot <= wdata[0];
  end

  default clocking cb @(posedge clk); endclocking

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_osc_state: assert property (!rst_n |=> !main_osc_en && !sub_osc_en && !hoco_en && loco_en)
    else $error("oscillator enables wrong in reset");
  a_reset_pins_free: assert property (!rst_n |=> port_pins_free && !cpu_clk && rdata == 8'h00)
    else $error("pins or clock wrong in reset");
  a_wdt_strap: assert property (disable iff (!rst_n) $rose(rst_n) |-> ##2 wdt_osc_en == !$past(boot_count_src_protect, 2))
    else $error("watchdog oscillator does not follow strap");
  a_main_latency: assert property (disable iff (!rst_n) main_wr |-> ##2 main_osc_en == !$past(wdata[5], 2))
    else $error("main oscillator enable late or wrong");
  a_hoco_latency: assert property (disable iff (!rst_n) hoco_wr |-> ##2 hoco_en == $past(wdata[2], 2))
    else $error("high-speed enable late or wrong");
  a_main_guard: assert property (disable iff (!rst_n) $changed(main_osc_en) |-> !$past(rst_n) || $past(main_wr, 2))
    else $error("main enable moved without a permitted write");
  a_hoco_guard: assert property (disable iff (!rst_n) $changed(hoco_en) |-> !$past(rst_n) || $past(hoco_wr, 2))
    else $error("high-speed enable moved without a permitted write");
  a_pin_sticky: assert property (disable iff (!rst_n) main_pins_osc |=> main_pins_osc)
    else $error("main pin routing released");
  a_clk_phase: assert property (disable iff (!rst_n) $changed(cpu_clk) |=> $stable(cpu_clk))
    else $error("cpu clock phase shorter than two cycles");
endmodule // csg_clock_gen_sva

`default_nettype wire

// File: dv/csg_clock_gen_tb.sv
/*
  Self-checking bench for csg_clock_gen: register port tasks and a
  table of run/stop writes. Assumes the checker file is compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module csg_clock_gen_tb;
  logic       clk, rst_n, strap, wr, rd, lost, prev;
  logic [7:0] addr, wdata, rd_val;
  logic [3:0] osc;
  logic       osc_ph;
  wire  [7:0] rdata;
  wire        main_osc_en, main_feedback_en, sub_osc_en, sub_feedback_en, hoco_en, loco_en;
  wire        wdt_osc_en, port_pins_free, main_pins_osc, sub_pins_osc, cpu_clk;
  wire  [7:0] en_vec  = {3'h0, main_osc_en, sub_osc_en, hoco_en, loco_en, wdt_osc_en};
  wire  [7:0] pin_vec = {3'h0, sub_pins_osc, main_feedback_en, sub_feedback_en, main_pins_osc, port_pins_free};
  int         num_errors, num_checks, cnt, i;
  // Address, data, expected {main, sub, hoco, loco, wdt}
  logic [20:0] tbl [10] = '{{8'h06, 8'h08, 5'b10011}, {8'h06, 8'h28, 5'b00011}, {8'h0c, 8'h05, 5'b00111},
    {8'h0c, 8'h09, 5'b00010}, {8'h0c, 8'h00, 5'b00011}, {8'h07, 8'h30, 5'b00001}, {8'h07, 8'h20, 5'b00011},
    {8'h0c, 8'h01, 5'b00011}, {8'h06, 8'h30, 5'b01011}, {8'h06, 8'h38, 5'b00011}};

  csg_clock_gen u_dut (.clk(clk), .rst_n(rst_n), .boot_count_src_protect(strap), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .main_clk_in(osc[0]), .sub_clk_in(osc[1]), .hoco_clk_in(osc[2]),
    .loco_clk_in(osc[3]), .main_osc_lost(lost), .main_osc_en(main_osc_en), .main_feedback_en(main_feedback_en),
    .sub_osc_en(sub_osc_en), .sub_feedback_en(sub_feedback_en), .hoco_en(hoco_en), .loco_en(loco_en),
    .wdt_osc_en(wdt_osc_en), .port_pins_free(port_pins_free), .main_pins_osc(main_pins_osc),
    .sub_pins_osc(sub_pins_osc), .cpu_clk(cpu_clk));

  // ----------------------------------------------------------------
  // Clock, oscillator levels, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Oscillators toggle every second cycle, so each phase spans two samples
  always @(posedge clk)
  begin
    osc_ph <= ~osc_ph;
    if (osc_ph)
      osc <= ~osc;
  end

  // Whole run is well under 2000 cycles
  initial
  begin
    #40000;
    num_errors++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    rd_val = rdata;
  endtask

  // Register lands one edge after the write, outputs one edge later
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, strap, wr, rd, lost, addr, wdata, osc, osc_ph, num_errors, num_checks} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    chk(en_vec, 8'h03);
    chk(pin_vec, 8'h0d);
    rd_reg(8'h06);
    chk(rd_val, 8'h28);
    rd_reg(8'h07);
    chk(rd_val, 8'h20);
    rd_reg(8'h0c);
    chk(rd_val, 8'h01);
    rd_reg(8'h30);
    chk(rd_val, 8'h00);
    $display("Test reset state done");
    wr_reg(8'h06, 8'h08);
    settle;
    chk(en_vec, 8'h03);
    rd_reg(8'h06);
    chk(rd_val, 8'h28);
    $display("Test refused write done");
    wr_reg(8'h0a, 8'h01);
    for (i = 0; i < 10; i++)
    begin
      wr_reg(tbl[i][20:13], tbl[i][12:5]);
      settle;
      chk(en_vec, {3'h0, tbl[i][4:0]});
    end
    $display("Test run and stop done");
    wr_reg(8'h07, 8'h2e);
    settle;
    chk(pin_vec, 8'h12);
    wr_reg(8'h07, 8'h20);
    settle;
    chk(pin_vec, 8'h1e);
    rd_reg(8'h07);
    chk(rd_val, 8'h28);
    $display("Test external clock pins done");
    wr_reg(8'h0c, 8'h07);
    settle;
    rd_reg(8'h0d);
    chk(rd_val & 8'h03, 8'h03);
    repeat (16) @(negedge clk);
    prev = cpu_clk;
    cnt  = 0;
    // Source toggles 32 times in 64 cycles; halved it toggles exactly 16
    repeat (64)
    begin
      @(negedge clk);
      if (cpu_clk !== prev)
        cnt++;
      prev = cpu_clk;
    end
    chk(8'(cnt == 16), 8'h01);
    wr_reg(8'h0c, 8'h01);
    settle;
    rd_reg(8'h0d);
    chk(rd_val & 8'h03, 8'h02);
    wr_reg(8'h0c, 8'h00);
    lost <= 1'b1;
    settle;
    rd_reg(8'h0c);
    chk(rd_val & 8'h01, 8'h01);
    @(posedge clk);
    lost <= 1'b0;
    $display("Test clock sources done");
    // Second reset with the strap high: watchdog oscillator comes up stopped
    strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    chk(en_vec, 8'h02);
    chk(pin_vec, 8'h0d);
    rd_reg(8'h0c);
    chk(rd_val, 8'h09);
    $display("Test strap reset done");
    wrap_up;
  end
endmodule // csg_clock_gen_tb

bind csg_clock_gen csg_clock_gen_sva u_sva (.clk(clk), .rst_n(rst_n), .boot_count_src_protect(boot_count_src_protect),
  .addr(addr), .wdata(wdata), .wr(wr), .rdata(rdata), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
  .hoco_en(hoco_en), .loco_en(loco_en), .wdt_osc_en(wdt_osc_en), .port_pins_free(port_pins_free),
  .main_pins_osc(main_pins_osc), .cpu_clk(cpu_clk));

`default_nettype wire
